/* File: design/asr_pkg.sv */
// Shared constants for the angle sensor register bank.
// Assumes one 200 MHz core clock and a byte-wide register pointer.
package asr_pkg;
  // Slave addresses of the two dies
  localparam logic [6:0] ASR_DEV_BOT = 7'h40;
  localparam logic [6:0] ASR_DEV_TOP = 7'h41;
  // Register pointer values
  localparam logic [7:0] ASR_A_START_HI = 8'h01;
  localparam logic [7:0] ASR_A_START_LO = 8'h02;
  localparam logic [7:0] ASR_A_STOP_HI = 8'h03;
  localparam logic [7:0] ASR_A_STOP_LO = 8'h04;
  localparam logic [7:0] ASR_A_SETUP_HI = 8'h07;
  localparam logic [7:0] ASR_A_SETUP_LO = 8'h08;
  localparam logic [7:0] ASR_A_FLAGS = 8'h0b;
  localparam logic [7:0] ASR_A_RAW_HI = 8'h0c;
  localparam logic [7:0] ASR_A_RAW_LO = 8'h0d;
  localparam logic [7:0] ASR_A_ANG_HI = 8'h0e;
  localparam logic [7:0] ASR_A_ANG_LO = 8'h0f;
  localparam logic [7:0] ASR_A_GAIN = 8'h1a;
  localparam logic [7:0] ASR_A_MAG_HI = 8'h1b;
  localparam logic [7:0] ASR_A_MAG_LO = 8'h1c;
  localparam logic [7:0] ASR_A_CMD = 8'hff;
  // Command codes
  localparam logic [7:0] ASR_CMD_BURN_POS = 8'h80;
  localparam logic [7:0] ASR_CMD_BURN_SETUP = 8'h40;
  localparam logic [7:0] ASR_CMD_RELOAD = 8'h01;
  // Setup word field positions
  localparam int ASR_F_PWR = 0;
  localparam int ASR_F_DB = 2;
  localparam int ASR_F_STAGE = 4;
  localparam int ASR_F_RATE = 6;
  localparam int ASR_F_SLOW = 8;
  localparam int ASR_F_FTH = 10;
  localparam int ASR_F_IDLE = 13;
  // Flags register bit positions
  localparam int ASR_F_OVF = 6;
  localparam int ASR_F_MD = 5;
  // Reset values (unburned fuses read zero)
  localparam logic [13:0] ASR_SETUP_RST = 14'h0000;
  localparam logic [11:0] ASR_POS_RST = 12'h000;
  // Lifetime limit of position burns
  localparam logic [1:0] ASR_BURN_LIMIT = 2'h2;
  // Output stage code that enables pulse-width output
  localparam logic [1:0] ASR_STAGE_PWM = 2'h2;
  // Lowest pulse repetition rate in Hz
  localparam logic [9:0] ASR_RATE_BASE_HZ = 10'h073;
  // Slowest filter step factor
  localparam logic [4:0] ASR_SLOW_MAX = 5'h10;

  // Serial byte engine states, encoded in Gray order as listed
  typedef enum logic [2:0] {
    ASR_ST_IDLE = 3'b000,
    ASR_ST_ADDR = 3'b001,
    ASR_ST_AACK = 3'b011,
    ASR_ST_PTR = 3'b010,
    ASR_ST_WR = 3'b110,
    ASR_ST_WACK = 3'b111,
    ASR_ST_RD = 3'b101,
    ASR_ST_RACK = 3'b100
  } asr_state_t;
endpackage

/* File: design/asr_pin_sync.sv */
// Synchroniser and bus condition detector for the serial pins.
// Assumes clock and data arrive asynchronously to i_clk.
`timescale 1ns/1ps
module asr_pin_sync
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Raw pins
  input wire logic i_scl,
  input wire logic i_sda,
  // Conditions, one-cycle pulses
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_start,
  output logic o_stop,
  // Settled data level
  output logic o_sda
);
  logic [2:0] scl_r; // Two sync stages plus history
  logic [2:0] sda_r; // Same for data

  // Stage 0 feeds stage 1 only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_r <= 3'h7;
      sda_r <= 3'h7;
    end else begin
      scl_r <= {scl_r[1:0], i_scl};
      sda_r <= {sda_r[1:0], i_sda};
    end
  end

  // Edges are seen between stages 1 and 2
  assign o_scl_rise = scl_r[1] & ~scl_r[2];
  assign o_scl_fall = ~scl_r[1] & scl_r[2];
  // Data moving while clock is high marks a frame edge
  assign o_start = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1];
  assign o_stop = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1];
  assign o_sda = sda_r[1];
endmodule // asr_pin_sync

/* File: design/asr_otp.sv */
// One-time memory model: fuse bits only ever go from 0 to 1.
// Assumes power-up is the only reset and burns are single pulses.
`timescale 1ns/1ps
module asr_otp
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Burn requests, one-cycle pulses
  input wire logic i_burn_pos,
  input wire logic i_burn_setup,
  // Values to burn
  input wire logic [11:0] i_start,
  input wire logic [11:0] i_stop,
  input wire logic [13:0] i_setup,
  // Fuse contents
  output logic [11:0] o_start,
  output logic [11:0] o_stop,
  output logic [13:0] o_setup,
  output logic [1:0] o_pos_burns
);
  // Fuse words and lifetime burn counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_start <= ASR_POS_RST;
      o_stop <= ASR_POS_RST;
      o_setup <= ASR_SETUP_RST;
      o_pos_burns <= 2'h0;
    end else begin
      // A fuse that is blown stays blown, hence the OR
      if (i_burn_pos) begin
        o_start <= o_start | i_start;
        o_stop <= o_stop | i_stop;
        o_pos_burns <= o_pos_burns + 2'h1;
      end
      if (i_burn_setup) begin
        o_setup <= o_setup | i_setup;
      end
    end
  end
endmodule // asr_otp

/* File: design/asr_bank.sv */
// Register bank of one die of the angle sensor, behind a serial slave.
// Assumes sensor inputs are on i_clk; only the pins need syncing.
`timescale 1ns/1ps
module asr_bank
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Die position strap, high for the top die
  input wire logic i_top_die,
  // Serial pins, data is open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  // Measurement inputs
  input wire logic [11:0] i_raw_angle,
  input wire logic i_raw_from_fast,
  input wire logic i_slow_filter_active,
  input wire logic [11:0] i_field_strength,
  input wire logic [7:0] i_gain_value,
  input wire logic [4:0] i_loop_flags,
  input wire logic i_magnet_detected,
  input wire logic i_conv_overflow,
  // Decoded setup and scaled angle
  output logic [1:0] o_power_select,
  output logic [2:0] o_low_power_level,
  output logic [1:0] o_output_deadband,
  output logic o_pwm_enable,
  output logic [9:0] o_pulse_rate_hz,
  output logic [4:0] o_slow_filter_factor,
  output logic [4:0] o_fast_filter_threshold,
  output logic o_auto_idle_timer,
  output logic [11:0] o_scaled_angle
);
  // Fast filter threshold table, zero meaning slow filter only
  function automatic logic [4:0] fth_lsb(input logic [2:0] code);
    case (code)
      3'h1: fth_lsb = 5'h06;
      3'h2: fth_lsb = 5'h07;
      3'h3: fth_lsb = 5'h09;
      3'h4: fth_lsb = 5'h12;
      3'h5: fth_lsb = 5'h15;
      3'h6: fth_lsb = 5'h18;
      3'h7: fth_lsb = 5'h0a;
      default: fth_lsb = 5'h00;
    endcase
  endfunction

  // Readable pointer values
  function automatic logic rd_ok(input logic [7:0] a);
    case (a)
      ASR_A_START_HI, ASR_A_START_LO, ASR_A_STOP_HI, ASR_A_STOP_LO,
      ASR_A_SETUP_HI, ASR_A_SETUP_LO, ASR_A_FLAGS, ASR_A_RAW_HI,
      ASR_A_RAW_LO, ASR_A_ANG_HI, ASR_A_ANG_LO, ASR_A_GAIN,
      ASR_A_MAG_HI, ASR_A_MAG_LO: rd_ok = 1'b1;
      default: rd_ok = 1'b0;
    endcase
  endfunction

  // Writable pointer values
  function automatic logic wr_ok(input logic [7:0] a);
    case (a)
      ASR_A_START_HI, ASR_A_START_LO, ASR_A_STOP_HI, ASR_A_STOP_LO,
      ASR_A_SETUP_HI, ASR_A_SETUP_LO, ASR_A_FLAGS, ASR_A_CMD: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  endfunction

  // Pin conditions
  logic scl_rise, scl_fall, bus_start, bus_stop, sda_in;
  // Engine state
  asr_state_t st_r, st_nxt;
  logic [3:0] cnt_r; // Bits seen in this byte
  logic [7:0] rx_r; // Received byte shifter
  logic [7:0] tx_r; // Transmit byte shifter
  logic [7:0] ptr_r; // Register pointer
  logic rw_r; // Direction of the current frame
  logic drive_r; // Pull data low
  logic nack_r; // Master refused the last read byte
  // Bank contents
  logic [11:0] start_r, stop_r;
  logic [13:0] setup_r;
  logic ovf_r; // Sticky overflow
  logic load_r; // Pending fuse load
  // Fuse side
  logic [11:0] fuse_start, fuse_stop;
  logic [13:0] fuse_setup;
  logic [1:0] pos_burns;

  asr_pin_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_scl_rise(scl_rise),
    .o_scl_fall(scl_fall),
    .o_start(bus_start),
    .o_stop(bus_stop),
    .o_sda(sda_in)
  );

  // Byte boundary and decode
  wire byte_end = scl_fall & (cnt_r == 4'h8);
  wire [6:0] my_addr = i_top_die ? ASR_DEV_TOP : ASR_DEV_BOT;
  wire addr_hit = (rx_r[7:1] == my_addr);
  wire ptr_ack = rd_ok(rx_r) | wr_ok(rx_r);
  wire data_ack = wr_ok(ptr_r);
  wire wr_stb = (st_r == ASR_ST_WR) & byte_end & data_ack;
  // High-byte pointers of live values re-read without reload
  wire ptr_back = (ptr_r == ASR_A_RAW_LO) | (ptr_r == ASR_A_ANG_LO) |
                  (ptr_r == ASR_A_MAG_LO);
  wire [7:0] ptr_inc = ptr_back ? ptr_r - 8'h01 : ptr_r + 8'h01;

  // Command decode; anything else is dropped
  wire cmd_stb = wr_stb & (ptr_r == ASR_A_CMD);
  wire burn_pos = cmd_stb & (rx_r == ASR_CMD_BURN_POS) &
                  i_magnet_detected & (pos_burns < ASR_BURN_LIMIT);
  wire burn_setup = cmd_stb & (rx_r == ASR_CMD_BURN_SETUP);
  wire reload = cmd_stb & (rx_r == ASR_CMD_RELOAD);

  // Angle relative to start, one code per raw step
  wire [11:0] rel_angle = i_raw_angle - start_r;
  wire [11:0] span = stop_r - start_r;
  wire narrowed = (stop_r != start_r);
  wire [11:0] ang_val = (narrowed && rel_angle > span) ? span : rel_angle;

  // Read data mux, unmapped pointers read zero
  logic [7:0] rd_data;
  always_comb begin
    case (ptr_r)
      ASR_A_START_HI: rd_data = {4'h0, start_r[11:8]};
      ASR_A_START_LO: rd_data = start_r[7:0];
      ASR_A_STOP_HI: rd_data = {4'h0, stop_r[11:8]};
      ASR_A_STOP_LO: rd_data = stop_r[7:0];
      ASR_A_SETUP_HI: rd_data = {2'h0, setup_r[13:8]};
      ASR_A_SETUP_LO: rd_data = setup_r[7:0];
      ASR_A_FLAGS: rd_data = {1'b0, ovf_r, i_magnet_detected, i_loop_flags};
      ASR_A_RAW_HI: rd_data = {i_raw_from_fast, i_slow_filter_active, 2'h0,
                               i_raw_angle[11:8]};
      ASR_A_RAW_LO: rd_data = i_raw_angle[7:0];
      ASR_A_ANG_HI: rd_data = {4'h0, o_scaled_angle[11:8]};
      ASR_A_ANG_LO: rd_data = o_scaled_angle[7:0];
      ASR_A_GAIN: rd_data = i_gain_value;
      ASR_A_MAG_HI: rd_data = {4'h0, i_field_strength[11:8]};
      ASR_A_MAG_LO: rd_data = i_field_strength[7:0];
      default: rd_data = 8'h00;
    endcase
  end

  // Next state of the byte engine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ASR_ST_IDLE: st_nxt = ASR_ST_IDLE;
      ASR_ST_ADDR: begin
        // Wrong address: stay off the bus until the next start
        if (byte_end) begin
          st_nxt = addr_hit ? ASR_ST_AACK : ASR_ST_IDLE;
        end
      end
      ASR_ST_AACK: begin
        if (scl_fall) begin
          st_nxt = rw_r ? ASR_ST_RD : ASR_ST_PTR;
        end
      end
      ASR_ST_PTR, ASR_ST_WR: begin
        if (byte_end) begin
          st_nxt = ASR_ST_WACK;
        end
      end
      ASR_ST_WACK: begin
        if (scl_fall) begin
          st_nxt = ASR_ST_WR;
        end
      end
      ASR_ST_RD: begin
        if (byte_end) begin
          st_nxt = ASR_ST_RACK;
        end
      end
      ASR_ST_RACK: begin
        if (scl_fall) begin
          st_nxt = nack_r ? ASR_ST_IDLE : ASR_ST_RD;
        end
      end
      default: st_nxt = ASR_ST_IDLE;
    endcase
    // Frame edges override everything
    if (bus_start) begin
      st_nxt = ASR_ST_ADDR;
    end else if (bus_stop) begin
      st_nxt = ASR_ST_IDLE;
    end
  end

  // State and bit counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= ASR_ST_IDLE;
      cnt_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        cnt_r <= 4'h0;
      end else if (scl_rise) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // Receive shifter, direction bit and read acknowledge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (scl_rise) begin
      rx_r <= {rx_r[6:0], sda_in};
      if (st_r == ASR_ST_ADDR && cnt_r == 4'h7) begin
        rw_r <= sda_in;
      end
      if (st_r == ASR_ST_RACK) begin
        nack_r <= sda_in;
      end else if (st_r == ASR_ST_AACK) begin
        nack_r <= 1'b0; // New read frame: forget the last refusal
      end
    end
  end

  // Pointer: loaded by the pointer byte, advanced after each data byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_r <= 8'h00;
    end else if (st_r == ASR_ST_PTR && byte_end) begin
      ptr_r <= rx_r;
    end else if ((st_r == ASR_ST_WR || st_r == ASR_ST_RD) && byte_end) begin
      ptr_r <= ptr_inc;
    end
  end

  // Data line drive and transmit shifter, changed on clock falling edges; start and stop also release the drive
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      drive_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (bus_start || bus_stop) begin
      drive_r <= 1'b0;
    end else if (scl_fall) begin
      case (st_r)
        ASR_ST_ADDR: drive_r <= byte_end & addr_hit;
        ASR_ST_PTR: drive_r <= byte_end & ptr_ack;
        ASR_ST_WR: drive_r <= byte_end & data_ack; // Bad pointer: no ack
        ASR_ST_AACK, ASR_ST_RACK: begin
          // Load next read byte; drive its first bit unless the master refused
          tx_r <= rd_data;
          drive_r <= (rw_r & ~nack_r) & ~rd_data[7];
        end
        ASR_ST_RD: begin
          tx_r <= {tx_r[6:0], 1'b0};
          drive_r <= ~byte_end & ~tx_r[6];
        end
        default: drive_r <= 1'b0;
      endcase
    end
  end

  // Position and setup registers, loaded from fuses after power-up
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      start_r <= ASR_POS_RST;
      stop_r <= ASR_POS_RST;
      setup_r <= ASR_SETUP_RST;
      load_r <= 1'b1;
    end else if (load_r || reload) begin
      start_r <= fuse_start;
      stop_r <= fuse_stop;
      setup_r <= fuse_setup;
      load_r <= 1'b0;
    end else if (wr_stb) begin
      case (ptr_r)
        ASR_A_START_HI: start_r[11:8] <= rx_r[3:0];
        ASR_A_START_LO: start_r[7:0] <= rx_r;
        ASR_A_STOP_HI: stop_r[11:8] <= rx_r[3:0];
        ASR_A_STOP_LO: stop_r[7:0] <= rx_r;
        ASR_A_SETUP_HI: setup_r[13:8] <= rx_r[5:0];
        ASR_A_SETUP_LO: setup_r[7:0] <= rx_r;
        default: start_r <= start_r;
      endcase
    end
  end

  // Sticky overflow: a new overflow wins over a clearing write
  wire ovf_clr = wr_stb & (ptr_r == ASR_A_FLAGS) & (rx_r == 8'h00);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ovf_r <= 1'b0;
    end else if (i_conv_overflow) begin
      ovf_r <= 1'b1;
    end else if (ovf_clr) begin
      ovf_r <= 1'b0;
    end
  end

  asr_otp u_otp (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_burn_pos(burn_pos),
    .i_burn_setup(burn_setup),
    .i_start(start_r),
    .i_stop(stop_r),
    .i_setup(setup_r),
    .o_start(fuse_start),
    .o_stop(fuse_stop),
    .o_setup(fuse_setup),
    .o_pos_burns(pos_burns)
  );

  // Field slices of the setup word
  wire [1:0] pwr = setup_r[ASR_F_PWR +: 2];
  wire [1:0] stage = setup_r[ASR_F_STAGE +: 2];
  wire [1:0] rate = setup_r[ASR_F_RATE +: 2];
  wire [1:0] slow = setup_r[ASR_F_SLOW +: 2];
  wire [2:0] fast_filter_threshold = setup_r[ASR_F_FTH +: 3];

  // Registered decoded outputs and scaled angle, one cycle behind the setup word or ang_val
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_power_select <= 2'h0;
      o_low_power_level <= 3'h0;
      o_output_deadband <= 2'h0;
      o_pwm_enable <= 1'b0;
      o_pulse_rate_hz <= ASR_RATE_BASE_HZ;
      o_slow_filter_factor <= ASR_SLOW_MAX;
      o_fast_filter_threshold <= 5'h00;
      o_auto_idle_timer <= 1'b0;
      o_scaled_angle <= 12'h000;
    end else begin
      o_power_select <= pwr;
      o_low_power_level <= {pwr == 2'h3, pwr == 2'h2, pwr == 2'h1};
      o_output_deadband <= setup_r[ASR_F_DB +: 2];
      o_pwm_enable <= (stage == ASR_STAGE_PWM);
      o_pulse_rate_hz <= ASR_RATE_BASE_HZ << rate;
      o_slow_filter_factor <= ASR_SLOW_MAX >> slow;
      o_fast_filter_threshold <= fth_lsb(fast_filter_threshold);
      o_auto_idle_timer <= setup_r[ASR_F_IDLE];
      o_scaled_angle <= ang_val;
    end
  end

  // Open drain: output level is always low, enable is active low
  assign o_sda = 1'b0;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_oe_n <= 1'b1;
    end else begin
      o_sda_oe_n <= ~drive_r;
    end
  end
endmodule // asr_bank

/* File: tb/asr_host.sv */
// Serial bus master model for the two-wire register port.
// Assumes a pull-up on SDA: the wire is the AND of all drivers.
`timescale 1ns/1ps
module asr_host (
  // Pins toward the wire
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  logic [6:0] dev = 7'h40; // Addressed die
  // Bus idle: both lines released high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // One bit: data set mid-low, sampled just before the falling edge
  task automatic bit_x(input logic b, output logic s);
    o_sda <= b;
    #12;
    o_scl <= 1'b1;
    #23;
    s = i_sda;
    #1;
    o_scl <= 1'b0;
    #12;
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    o_sda <= 1'b1;
    #12;
    o_scl <= 1'b1;
    #24;
    o_sda <= 1'b0;
    #24;
    o_scl <= 1'b0;
    #12;
  endtask
  // Stop: SDA rises while SCL is high, bus left idle
  task automatic stop();
    o_sda <= 1'b0;
    #12;
    o_scl <= 1'b1;
    #24;
    o_sda <= 1'b1;
    #24;
  endtask
  // Byte MSB first, then the ninth bit; released bits read the wire
  task automatic byte_x(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                        output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(nine, ack);
  endtask
  // Write n data bytes of d after the pointer; ack is the last one's
  task automatic wr(input logic [7:0] ptr, input int n, input logic [15:0] d,
                    output logic ack);
    logic [7:0] r;
    start();
    byte_x({dev, 1'b0}, 1'b1, r, ack);
    byte_x(ptr, 1'b1, r, ack);
    for (int k = n - 1; k >= 0; k--) begin
      byte_x(d[8*k +: 8], 1'b1, r, ack);
    end
    stop();
  endtask
  // Set pointer, repeated start, read n bytes; last one is refused
  task automatic rd(input logic [7:0] ptr, input int n, output logic [23:0] q);
    logic [7:0] r;
    logic a;
    q = 24'h000000;
    start();
    byte_x({dev, 1'b0}, 1'b1, r, a);
    byte_x(ptr, 1'b1, r, a);
    start();
    byte_x({dev, 1'b1}, 1'b1, r, a);
    for (int k = 0; k < n; k++) begin
      byte_x(8'hff, k == n - 1, r, a);
      q = {q[15:0], r};
    end
    stop();
  endtask
  // Address byte only, to see whether a die answers
  task automatic probe(input logic [6:0] a7, output logic ack);
    logic [7:0] r;
    start();
    byte_x({a7, 1'b0}, 1'b1, r, ack);
    stop();
  endtask
endmodule // asr_host

/* File: tb/asr_bank_monitor.sv */
// Port-level checker for the register bank, bound to asr_bank.
// Assumes one clock domain and an active-high async reset.
`timescale 1ns/1ps
module asr_bank_monitor (
  // Clock, reset, pins
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  // Decoded setup
  input wire logic [1:0] o_power_select,
  input wire logic [2:0] o_low_power_level,
  input wire logic [9:0] o_pulse_rate_hz,
  input wire logic [4:0] o_slow_filter_factor,
  input wire logic [4:0] o_fast_filter_threshold
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [3:0] since_fall_r; // Cycles since the raw SCL pin fell
  // Saturating; the raw pin is watched, so sync delay sits inside the bound
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      since_fall_r <= 4'hf;
    end else if ($fell(i_scl)) begin
      since_fall_r <= 4'h0;
    end else if (since_fall_r != 4'hf) begin
      since_fall_r <= since_fall_r + 4'h1;
    end
  end
  // SCL seen high for four samples running
  sequence s_scl_high;
    i_scl [*4];
  endsequence
  // First sample after reset is released
  sequence s_pwr_up;
    $fell(i_rst);
  endsequence
  AST_OD_LOW: assert property (o_sda == 1'b0)
    else $error("serial data level not low");
  AST_SDA_HOLD: assert property (s_scl_high |-> $stable(o_sda_oe_n))
    else $error("data drive moved while clock high");
  AST_SDA_MOVE: assert property ($changed(o_sda_oe_n) |-> since_fall_r <= 4'h7)
    else $error("data drive moved away from clock fall");
  AST_PWR_UP: assert property (s_pwr_up |-> o_sda_oe_n && o_pulse_rate_hz == 10'd115
    && o_slow_filter_factor == 5'd16)
    else $error("outputs not at unburned values after reset");
  AST_LOW_POWER: assert property (o_low_power_level == ((o_power_select == 2'h0) ? 3'h0
    : (3'h1 << (o_power_select - 2'h1))))
    else $error("low power level disagrees with power field");
  AST_RATE: assert property (o_pulse_rate_hz inside {10'd115, 10'd230, 10'd460, 10'd920})
    else $error("pulse rate not a listed value");
  AST_SLOW: assert property (o_slow_filter_factor inside {5'd16, 5'd8, 5'd4, 5'd2})
    else $error("slow filter factor not a listed value");
  AST_FAST_THR: assert property (o_fast_filter_threshold inside
    {5'd0, 5'd6, 5'd7, 5'd9, 5'd18, 5'd21, 5'd24, 5'd10})
    else $error("fast threshold not a listed value");
endmodule // asr_bank_monitor

bind asr_bank asr_bank_monitor u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
  .o_power_select(o_power_select), .o_low_power_level(o_low_power_level),
  .o_pulse_rate_hz(o_pulse_rate_hz), .o_slow_filter_factor(o_slow_filter_factor),
  .o_fast_filter_threshold(o_fast_filter_threshold)
);

/* File: tb/asr_bank_bench.sv */
// Self-checking bench for the angle sensor register bank.
// Assumes the host model owns the serial pins; sensor inputs are levels.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module asr_bank_bench;
  import asr_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_top_die = 1'b0;
  logic i_magnet_detected = 1'b0;
  logic i_conv_overflow = 1'b0;
  logic i_raw_from_fast = 1'b0;
  logic i_slow_filter_active = 1'b0;
  logic [11:0] i_raw_angle = 12'h000;
  logic [11:0] i_field_strength = 12'h000;
  logic [7:0] i_gain_value = 8'h00;
  logic [4:0] i_loop_flags = 5'h00;
  logic scl, sda_m, o_sda, o_sda_oe_n, o_pwm_enable, o_auto_idle_timer, ack;
  logic [1:0] o_power_select, o_output_deadband, c;
  logic [2:0] o_low_power_level;
  logic [4:0] o_slow_filter_factor, o_fast_filter_threshold;
  logic [9:0] o_pulse_rate_hz;
  logic [11:0] o_scaled_angle;
  logic [13:0] w;
  logic [23:0] q;
  logic [4:0] rows [8] = '{5'd0, 5'd6, 5'd7, 5'd9, 5'd18, 5'd21, 5'd24, 5'd10}; // Thresholds
  logic [15:0] pv [3] = '{16'h0100, 16'h0023, 16'h0400}; // Start values to burn
  int num_errors = 0;
  int n_checks = 0;
  wire sda = sda_m & (o_sda_oe_n | o_sda); // Open drain with pull-up
  always #2.5 i_clk = ~i_clk;
  asr_host u_host (.o_scl(scl), .o_sda(sda_m), .i_sda(sda));
  asr_bank u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_top_die(i_top_die), .i_scl(scl), .i_sda(sda),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_raw_angle(i_raw_angle),
    .i_raw_from_fast(i_raw_from_fast), .i_slow_filter_active(i_slow_filter_active),
    .i_field_strength(i_field_strength), .i_gain_value(i_gain_value),
    .i_loop_flags(i_loop_flags), .i_magnet_detected(i_magnet_detected),
    .i_conv_overflow(i_conv_overflow), .o_power_select(o_power_select),
    .o_low_power_level(o_low_power_level), .o_output_deadband(o_output_deadband),
    .o_pwm_enable(o_pwm_enable), .o_pulse_rate_hz(o_pulse_rate_hz),
    .o_slow_filter_factor(o_slow_filter_factor),
    .o_fast_filter_threshold(o_fast_filter_threshold),
    .o_auto_idle_timer(o_auto_idle_timer), .o_scaled_angle(o_scaled_angle)
  );
  // Wait n edges, then step past them so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Read n bytes from pointer p and compare against e
  task automatic rchk(input string nm, input logic [7:0] p, input int n, input logic [23:0] e);
    u_host.rd(p, n, q);
    `CHK(nm, e, q)
  endtask
  // One byte into the command register
  task automatic cmd(input logic [7:0] v);
    u_host.wr(ASR_A_CMD, 1, {8'h00, v}, ack);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog, well beyond the expected run of about 110 us
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(6);
    `CHK("rate", 10'd115, o_pulse_rate_hz)
    `CHK("slow", 5'd16, o_slow_filter_factor)
    rchk("setup", ASR_A_SETUP_HI, 2, 24'h0);
    rchk("start", ASR_A_START_HI, 2, 24'h0);
    // Each die answers its own address only; a foreign one never
    for (int d = 0; d < 2; d++) begin
      @(posedge i_clk);
      i_top_die <= d[0];
      u_host.probe(7'h40 + 7'(d), ack);
      `CHK("own", 1'b0, ack)
      u_host.probe(7'h41 - 7'(d), ack);
      `CHK("other", 1'b1, ack)
      u_host.probe(7'h42, ack);
      `CHK("foreign", 1'b1, ack)
    end
    u_host.dev = ASR_DEV_TOP;
    // Rows: every code of every setup field, threshold from the table
    for (int i = 0; i < 8; i++) begin
      c = 2'(i);
      w = {i[0], i[2:0], c, c, c, c, c};
      u_host.wr(ASR_A_SETUP_HI, 2, {2'b00, w}, ack);
      tick(3);
      `CHK("pwr", c, o_power_select)
      `CHK("lvl", (c == 2'h0) ? 3'h0 : (3'h1 << (c - 2'h1)), o_low_power_level)
      `CHK("band", c, o_output_deadband)
      `CHK("pwm", c == 2'h2, o_pwm_enable)
      `CHK("rate", 10'd115 << c, o_pulse_rate_hz)
      `CHK("slow", 5'd16 >> c, o_slow_filter_factor)
      `CHK("fast", rows[i], o_fast_filter_threshold)
      `CHK("idle", i[0], o_auto_idle_timer)
      rchk("setup", ASR_A_SETUP_HI, 2, {10'h0, w});
    end
    u_host.wr(ASR_A_START_HI, 2, 16'h0100, ack);
    u_host.wr(ASR_A_STOP_HI, 2, 16'h0900, ack); // Span of half a turn
    rchk("start", ASR_A_START_HI, 2, 24'h000100);
    rchk("stop", ASR_A_STOP_HI, 2, 24'h000900);
    @(posedge i_clk);
    i_raw_angle <= 12'h900;
    i_raw_from_fast <= 1'b1;
    i_slow_filter_active <= 1'b1;
    i_gain_value <= 8'h5a;
    i_field_strength <= 12'hb3c;
    tick(3);
    `CHK("angle", 12'h800, o_scaled_angle) // Half turn is 2048 codes
    rchk("angle", ASR_A_ANG_HI, 2, 24'h000800);
    rchk("raw", ASR_A_RAW_HI, 3, 24'hc900c9); // Pointer returns to high byte
    rchk("gain", ASR_A_GAIN, 3, 24'h5a0b3c);
    rchk("hole", 8'h05, 1, 24'h0);
    u_host.wr(ASR_A_RAW_HI, 1, 16'h00ff, ack);
    `CHK("ro", 1'b1, ack)
    // Overflow stays until zero is written; other writes leave it
    @(posedge i_clk);
    i_loop_flags <= 5'h15;
    i_conv_overflow <= 1'b1;
    @(posedge i_clk);
    i_conv_overflow <= 1'b0;
    rchk("flags", ASR_A_FLAGS, 1, 24'h55);
    u_host.wr(ASR_A_FLAGS, 1, 16'h0001, ack);
    rchk("flags", ASR_A_FLAGS, 1, 24'h55);
    u_host.wr(ASR_A_FLAGS, 1, 16'h0000, ack);
    rchk("flags", ASR_A_FLAGS, 1, 24'h15);
    // Position burn without a magnet must not reach the fuses
    cmd(ASR_CMD_BURN_POS);
    u_host.wr(ASR_A_START_HI, 2, 16'h0abc, ack);
    cmd(ASR_CMD_RELOAD);
    rchk("nomag", ASR_A_START_HI, 2, 24'h0);
    @(posedge i_clk);
    i_magnet_detected <= 1'b1;
    rchk("flags", ASR_A_FLAGS, 1, 24'h35);
    u_host.wr(ASR_A_STOP_HI, 2, 16'h0900, ack); // Reload cleared it
    // Three burns; only the first two may count
    for (int k = 0; k < 3; k++) begin
      u_host.wr(ASR_A_START_HI, 2, pv[k], ack);
      cmd(ASR_CMD_BURN_POS);
    end
    cmd(8'h11);
    rchk("ignored", ASR_A_START_HI, 2, 24'h000400);
    cmd(ASR_CMD_RELOAD);
    rchk("burned", ASR_A_START_HI, 2, 24'h000123);
    rchk("burned", ASR_A_STOP_HI, 2, 24'h000900);
    // Read-modify-write of the stage field, then burn the setup word
    u_host.rd(ASR_A_SETUP_HI, 2, q);
    w = q[13:0] ^ 14'h0030;
    u_host.wr(ASR_A_SETUP_HI, 2, {2'b00, w}, ack);
    cmd(ASR_CMD_BURN_SETUP);
    u_host.wr(ASR_A_SETUP_HI, 2, 16'h0000, ack);
    cmd(ASR_CMD_RELOAD);
    rchk("setup", ASR_A_SETUP_HI, 2, {10'h0, w});
    print_verdict();
  end
endmodule // asr_bank_bench
